// File: host_port.sv
// Behavioural host serial port that frames control bytes and collects results
module host_port (
  input  wire logic sys_clk,
  input  wire logic sdo,
  output      logic sck,
  output      logic sdi
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Frame of lead idle clocks plus 24 clocks, 80 ns per clock
  // ----------------------------------------------------------------
  // Clock stands still between frames so the panel can settle
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
  end

  task automatic frame(input logic [7:0] ctl, input int lead, output logic [23:0] got);
    int i;
    got = '0;
    for (i = 0; i < lead + 24; i++) begin
      sdi <= (i >= lead && i < lead + 8) ? ctl[7 - (i - lead)] : 1'b0;
      repeat (4) @(posedge sys_clk);
      sck <= 1'b1;
      got = {got[22:0], sdo};
      repeat (4) @(posedge sys_clk);
      sck <= 1'b0;
    end
  endtask : frame

  // Two 12-bit conversions, second byte starting 15 clocks after the first
  task automatic pair(input logic [7:0] ctl, output logic [38:0] got);
    int i;
    got = '0;
    for (i = 0; i < 39; i++) begin
      sdi <= (i < 8) ? ctl[7 - i] : ((i >= 15 && i < 23) ? ctl[22 - i] : 1'b0);
      repeat (4) @(posedge sys_clk);
      sck <= 1'b1;
      got = {got[37:0], sdo};
      repeat (4) @(posedge sys_clk);
      sck <= 1'b0;
    end
  endtask : pair
endmodule : host_port

// File: pin_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output      logic [WIDTH-1:0] sync_out
);
  import touch_pkg::*;

  logic [1:0][WIDTH-1:0] stage_reg;
  logic [1:0][WIDTH-1:0] stage_next;

  always_comb begin
    stage_next = {stage_reg[0], async_in};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= stage_next;
    end
  end

  assign sync_out = stage_reg[1];

endmodule : pin_sync

// File: tb_touch_adc_serial_sequencer.sv
// Self-checking bench of the touch converter serial sequencer
module tb_touch_adc_serial_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import touch_pkg::*;

  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        sck;
  logic        sdi;
  logic        sdo;
  logic [11:0] code    = 12'h3C6;
  axi_req_t    req     = '0;
  axi_rsp_t    rsp;
  panel_t      panel;
  int          num_errors = 0;
  int          n_checks   = 0;
  int          cnt[6];
  logic        busy;

  touch_adc_serial_sequencer dut_u (.SYS_CLK(sys_clk), .RST_N(rst_n), .SHIFT_CLOCK(sck),
    .SERIAL_IN(sdi), .CONV_CODE(code), .S_AXI_REQ(req), .S_AXI_RSP(rsp), .SERIAL_OUT(sdo),
    .PANEL(panel));
  host_port host_u (.sys_clk(sys_clk), .sdo(sdo), .sck(sck), .sdi(sdi));

  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
      num_errors++;
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge sys_clk);
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge sys_clk);
  endtask : axr

  // Frame with panel activity counted in system clocks
  task automatic run(input logic [7:0] ctl, input int lead, output logic [23:0] got);
    cnt = '{default: 0};
    busy = 1'b1;
    fork
      begin
        host_u.frame(ctl, lead, got);
        busy = 1'b0;
      end
      while (busy) begin
        @(posedge sys_clk);
        cnt[0] += panel.pen_diode;
        cnt[1] += panel.temp_bias;
        cnt[2] += panel.temp_bias_x91;
        cnt[3] += panel.battery_div;
        cnt[4] += panel.sample_hold;
        cnt[5] += panel.sample_hold & !panel.y_plus;
      end
    join
    repeat (8) @(posedge sys_clk);
  endtask : run

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    panel_t      e;
    logic [31:0] d;
    logic [1:0]  r;
    e = '0;
    e.y_minus = 1'b1;
    e.pen_touch_irq_en = 1'b1;
    e.ref_differential = 1'b1;
    chk("panel", {16'h0000, e}, {16'h0000, panel});
    chk("serial_out", 32'h0, {31'h0, sdo});
    axr(OFF_CONTROL, d, r);
    chk("control", 32'h1, d);
    axr(OFF_TEST_CODE, d, r);
    chk("test_code", 32'h0, d);
    axr(8'h20, d, r);
    chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped_data", 32'h0, d);
  endtask : t_reset

  // Both resolutions, live and test code, idle zeros before the start bit
  task automatic t_result();
    logic [23:0] g;
    logic [31:0] d;
    logic [1:0]  r;
    run(8'h94, 3, g);
    chk("frame12", {9'h0, 12'h3C6, 3'h0}, {8'h0, g});
    chk("hold12", 32'd100, cnt[4]);
    axr(OFF_RESULT, d, r);
    chk("result", 32'h3C6, d);
    axw(OFF_TEST_CODE, 32'hA5C, r);
    chk("wr_resp", {30'h0, RESP_OKAY}, {30'h0, r});
    axw(OFF_CONTROL, 32'h3, r);
    run(8'hB8, 0, g);
    chk("frame8", {9'h0, 8'hA5, 7'h0}, {8'h0, g});
    chk("hold8", 32'd68, cnt[4]);
    run(8'h94, 0, g);
    chk("frame_test", {9'h0, 12'hA5C, 3'h0}, {8'h0, g});
  endtask : t_result

  task automatic t_channels();
    logic [23:0] g;
    logic [2:0]  ch[3] = '{CH_TEMP0, CH_BATT, CH_TEMP1};
    int          e[3][4] = '{'{24, 24, 0, 0}, '{0, 0, 0, 24}, '{0, 24, 24, 0}};
    int          i;
    int          k;
    for (i = 0; i < 3; i++) begin
      run({1'b1, ch[i], 4'h4}, 0, g);
      for (k = 0; k < 4; k++) begin
        chk("acq_count", e[i][k], cnt[k]);
      end
    end
  endtask : t_channels

  // Differential Y measurement under every power-down code
  task automatic t_power();
    logic [23:0] g;
    logic [1:0]  pd;
    int          i;
    for (i = 0; i < 4; i++) begin
      pd = ~i[1:0];
      run({6'h24, pd}, 0, g);
      chk("drv_in_conv", 32'h0, cnt[5]);
      chk("drv_after", {31'h0, pd == PD_ALWAYS_ON}, {31'h0, panel.y_plus});
      chk("ref_on", {31'h0, pd[1]}, {31'h0, panel.reference_on});
      chk("conv_on", {31'h0, pd[0]}, {31'h0, panel.converter_on});
      chk("irq_en", {31'h0, !pd[0]}, {31'h0, panel.pen_touch_irq_en});
    end
  endtask : t_power

  // Overlapped bytes: results 15 clocks apart, drivers kept on with select 11
  task automatic t_overlap();
    logic [38:0] g;
    host_u.pair(8'h93, g);
    repeat (8) @(posedge sys_clk);
    chk("overlap_a", {8'h0, 9'h0, 12'hA5C, 3'h0}, {8'h0, g[38:15]});
    chk("overlap_b", {17'h0, 12'hA5C, 3'h0}, {17'h0, g[14:0]});
    chk("overlap_drv", 32'h1, {31'h0, panel.y_plus});
  endtask : t_overlap

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_result();
    t_channels();
    t_overlap();
    t_power();
    wrap_up();
  end

  // Roughly twelve frames of 2 us are expected
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
endmodule : tb_touch_adc_serial_sequencer

// File: touch_adc_serial_sequencer.sv
// Serial conversion sequencer of a four-wire touch screen converter
// Behaviour
// - Power-down select 11 keeps device powered and panel drivers on, except at a single-ended hold.
// - Overlapped 15-clock ratiometric conversions keep drivers on until told to stop.
// - Channel 000 turns on pen diode and routes it to converter.
// - Channel 111 measures temperature diode at 91 times bias current.
// - Temperature bias current flows only during the three acquisition clocks.
// - Battery divider is on only while acquiring channel 010.
// - Exchanges are eight clocks; a conversion takes 24 clocks.
// - Acquisition starts and switches close once channel bits are known.
// - Three clocks after acquisition starts, device enters hold and converts.
// - Single-ended, battery and temperature modes may drop drivers at hold.
// - Conversion runs over the twelve clocks after hold, eight at 8-bit resolution.
// - Ratiometric mode keeps drivers on throughout the conversion.
// - A thirteenth clock delivers the last result bit, a ninth at 8-bit resolution.
// - Padding clocks, three at 12 bits and seven at 8 bits, drive serial output low and are ignored.
// - Control byte order: start, channel, resolution, reference, power-down.
// - Serial input is ignored until the first high start bit.
// - Resolution bit low gives 12 bits, high gives 8 bits.
// - Power-down select sets reference, converter and pen interrupt enable.
module touch_adc_serial_sequencer (
  input  wire logic               SYS_CLK,
  input  wire logic               RST_N,
  input  wire logic               SHIFT_CLOCK,
  input  wire logic               SERIAL_IN,
  input  wire logic [11:0]        CONV_CODE,
  input  wire touch_pkg::axi_req_t S_AXI_REQ,
  output      touch_pkg::axi_rsp_t S_AXI_RSP,
  output      logic               SERIAL_OUT,
  output      touch_pkg::panel_t  PANEL
);
  import touch_pkg::*;

  typedef struct packed {
    logic        sck_q;
    logic [3:0]  rx_cnt;
    logic [7:0]  rx_shift;
    logic        acq;
    logic [2:0]  acq_ch;
    ctrl_t       cfg;
    logic        conv_act;
    logic [4:0]  conv_rise;
    logic [4:0]  conv_fall;
    logic [11:0] code;
    logic        sdo;
    panel_t      pins;
    logic        link_en;
    logic        use_test;
    logic [11:0] test_code;
    logic [11:0] last_code;
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    axi_rsp_t    rsp;
  } state_t;

  state_t      st_reg;
  state_t      st_next;
  logic [13:0] sync_v;
  logic        sck_s;
  logic        sdi_s;
  logic [11:0] code_s;
  logic        rise;
  logic        fall;

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  // Panel switches per channel: {x+, x-, y+, y-}
  function automatic logic [3:0] drivers(input logic [2:0] ch);
    case (ch)
      3'h1:    return 4'h3;
      3'h3:    return 4'h6;
      3'h4:    return 4'h6;
      3'h5:    return 4'hC;
      default: return 4'h0;
    endcase
  endfunction : drivers

  function automatic logic [4:0] res_bits(input ctrl_t c);
    return c.mode_8bit ? RES_BITS_LO : RES_BITS_HI;
  endfunction : res_bits

  // ----------------------------------------------------------------
  // Pin inputs
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH (14)
  ) u_sync (
    .clk      (SYS_CLK),
    .rst_n    (RST_N),
    .async_in ({SHIFT_CLOCK, SERIAL_IN, CONV_CODE}),
    .sync_out (sync_v)
  );

  assign sck_s  = sync_v[13];
  assign sdi_s  = sync_v[12];
  assign code_s = sync_v[11:0];
  assign rise   = st_reg.link_en && sck_s && !st_reg.sck_q;
  assign fall   = st_reg.link_en && !sck_s && st_reg.sck_q;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0]  drv;
    logic [2:0]  ch;
    logic        conv;
    logic        drv_on;
    logic [1:0]  pd;
    drv    = 4'h0;
    ch     = 3'h0;
    conv   = 1'b0;
    drv_on = 1'b0;
    pd     = 2'h0;
    st_next = st_reg;
    st_next.sck_q = sck_s;

    // AXI write: address and data in either order
    if (st_reg.rsp.awready && S_AXI_REQ.awvalid) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = S_AXI_REQ.awaddr;
    end
    if (st_reg.rsp.wready && S_AXI_REQ.wvalid) begin
      st_next.w_got = 1'b1;
      st_next.wdata = S_AXI_REQ.wdata;
      st_next.wstrb = S_AXI_REQ.wstrb;
    end
    if (st_reg.rsp.bvalid && S_AXI_REQ.bready) begin
      st_next.rsp.bvalid = 1'b0;
    end
    if (st_next.aw_got && st_next.w_got && !st_next.rsp.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp = RESP_OKAY;
      if (st_next.awaddr == OFF_CONTROL) begin
        if (st_next.wstrb[0]) begin
          st_next.link_en = st_next.wdata[0];
          st_next.use_test = st_next.wdata[1];
        end
      end else if (st_next.awaddr == OFF_TEST_CODE) begin
        if (st_next.wstrb[0]) begin
          st_next.test_code[7:0] = st_next.wdata[7:0];
        end
        if (st_next.wstrb[1]) begin
          st_next.test_code[11:8] = st_next.wdata[11:8];
        end
      end else if (st_next.awaddr == OFF_STATUS || st_next.awaddr == OFF_RESULT) begin
        st_next.rsp.bresp = RESP_OKAY;
      end else begin
        st_next.rsp.bresp = RESP_SLVERR;
      end
    end
    st_next.rsp.awready = !st_next.aw_got && !st_next.rsp.bvalid;
    st_next.rsp.wready = !st_next.w_got && !st_next.rsp.bvalid;

    // AXI read
    if (st_reg.rsp.rvalid && S_AXI_REQ.rready) begin
      st_next.rsp.rvalid = 1'b0;
    end
    if (st_reg.rsp.arready && S_AXI_REQ.arvalid) begin
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rresp = RESP_OKAY;
      if (S_AXI_REQ.araddr == OFF_CONTROL) begin
        st_next.rsp.rdata = {30'h0, st_reg.use_test, st_reg.link_en};
      end else if (S_AXI_REQ.araddr == OFF_TEST_CODE) begin
        st_next.rsp.rdata = {20'h0, st_reg.test_code};
      end else if (S_AXI_REQ.araddr == OFF_STATUS) begin
        st_next.rsp.rdata = {18'h0, st_reg.rx_cnt, st_reg.conv_act, st_reg.acq, st_reg.cfg};
      end else if (S_AXI_REQ.araddr == OFF_RESULT) begin
        st_next.rsp.rdata = {20'h0, st_reg.last_code};
      end else begin
        st_next.rsp.rdata = 32'h0;
        st_next.rsp.rresp = RESP_SLVERR;
      end
    end
    st_next.rsp.arready = !st_next.rsp.rvalid;

    // ----------------------------------------------------------------
    // Serial link, stepped by shift clock edges
    // ----------------------------------------------------------------
    if (!st_reg.link_en) begin
      st_next.rx_cnt = 4'h0;
      st_next.acq = 1'b0;
      st_next.conv_act = 1'b0;
      st_next.sdo = 1'b0;
    end
    if (rise) begin
      if (st_reg.rx_cnt != 4'h0) begin
        st_next.rx_shift = {st_reg.rx_shift[6:0], sdi_s};
        st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
      end else if (sdi_s && (!st_reg.conv_act
                   || st_reg.conv_rise >= res_bits(st_reg.cfg) - OVERLAP_LEAD)) begin
        // Start may overlap the tail of the previous result
        st_next.rx_shift = 8'h01;
        st_next.rx_cnt = 4'h1;
      end
      if (st_reg.conv_act) begin
        st_next.conv_rise = st_reg.conv_rise + 5'h01;
        if (st_next.conv_rise == CONV_RISES) begin
          st_next.conv_act = 1'b0;
        end
      end
    end
    if (fall) begin
      if (st_reg.rx_cnt == ACQ_START_BITS) begin
        st_next.acq = 1'b1;
        st_next.acq_ch = st_reg.rx_shift[3:1];
      end
      if (st_reg.rx_cnt == CTRL_BITS) begin
        // Hold; the code is taken here so a late change cannot tear it
        st_next.acq = 1'b0;
        st_next.cfg = ctrl_t'(st_reg.rx_shift);
        st_next.conv_act = 1'b1;
        st_next.conv_rise = 5'h00;
        st_next.conv_fall = 5'h00;
        st_next.rx_cnt = 4'h0;
        st_next.code = st_reg.use_test ? st_reg.test_code : code_s;
        st_next.last_code = st_next.code;
        st_next.sdo = 1'b0;
      end else if (st_reg.conv_act) begin
        st_next.conv_fall = st_reg.conv_fall + 5'h01;
        if (st_reg.conv_fall < res_bits(st_reg.cfg)) begin
          st_next.sdo = st_reg.code[4'(RES_MSB - st_reg.conv_fall)];
        end else begin
          st_next.sdo = 1'b0;
        end
      end
    end

    // ----------------------------------------------------------------
    // Panel switches and power
    // ----------------------------------------------------------------
    ch = st_next.acq ? st_next.acq_ch : st_next.cfg.channel_select;
    pd = {st_next.cfg.power_down_select_high, st_next.cfg.power_down_select_low};
    conv = st_next.conv_act && (st_next.conv_rise <= res_bits(st_next.cfg));
    drv = drivers(ch);
    drv_on = st_next.acq
             || (conv && !st_next.cfg.reference_mode_select)
             || (!conv && pd == PD_ALWAYS_ON);
    st_next.pins.x_plus = drv_on && drv[3];
    st_next.pins.x_minus = drv_on && drv[2];
    st_next.pins.y_plus = drv_on && drv[1];
    // Y- stays closed in auto power-down for pen detection
    st_next.pins.y_minus = (drv_on && drv[0])
                           || (!drv_on && !st_next.acq && !conv && pd == PD_AUTO);
    st_next.pins.pen_diode = st_next.acq && ch == CH_TEMP0;
    st_next.pins.temp_bias = st_next.acq && (ch == CH_TEMP0 || ch == CH_TEMP1);
    st_next.pins.temp_bias_x91 = st_next.acq && ch == CH_TEMP1;
    st_next.pins.battery_div = st_next.acq && ch == CH_BATT;
    st_next.pins.sample_hold = conv;
    st_next.pins.reference_on = st_next.cfg.power_down_select_high;
    st_next.pins.converter_on = st_next.acq || conv || st_next.cfg.power_down_select_low;
    st_next.pins.pen_touch_irq_en = !st_next.cfg.power_down_select_low
                                    && !st_next.acq && !conv;
    st_next.pins.ref_differential = !st_next.cfg.reference_mode_select;
    st_next.pins.mux_select = ch;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= '0;
      st_reg.link_en <= LINK_EN_RST;
      st_reg.use_test <= USE_TEST_RST;
      st_reg.test_code <= TEST_CODE_RST;
      st_reg.rsp.awready <= 1'b1;
      st_reg.rsp.wready <= 1'b1;
      st_reg.rsp.arready <= 1'b1;
      st_reg.pins.y_minus <= 1'b1;
      st_reg.pins.pen_touch_irq_en <= 1'b1;
      st_reg.pins.ref_differential <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign S_AXI_RSP  = st_reg.rsp;
  assign SERIAL_OUT = st_reg.sdo;
  assign PANEL      = st_reg.pins;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  property p_hold_after_byte;
    fall && st_reg.rx_cnt == CTRL_BITS |=> st_reg.conv_act && st_reg.pins.sample_hold
      && st_reg.conv_fall == 5'h00 && !st_reg.acq;
  endproperty
  a_hold_after_byte: assert property (p_hold_after_byte)
    else $error("hold not entered after control byte");

  property p_acq_start;
    fall && st_reg.rx_cnt == ACQ_START_BITS |=> st_reg.acq && st_reg.pins.converter_on;
  endproperty
  a_acq_start: assert property (p_acq_start)
    else $error("acquisition not started after channel bits");

  property p_bias_only_acq;
    PANEL.temp_bias |-> st_reg.acq && (st_reg.acq_ch == CH_TEMP0 || st_reg.acq_ch == CH_TEMP1);
  endproperty
  a_bias_only_acq: assert property (p_bias_only_acq)
    else $error("temperature bias outside acquisition");

  property p_bias_x91;
    st_reg.acq && st_reg.acq_ch == CH_TEMP1 |-> PANEL.temp_bias_x91 && !PANEL.pen_diode;
  endproperty
  a_bias_x91: assert property (p_bias_x91)
    else $error("high bias missing on channel 111");

  property p_battery;
    PANEL.battery_div == (st_reg.acq && st_reg.acq_ch == CH_BATT);
  endproperty
  a_battery: assert property (p_battery)
    else $error("battery divider out of acquisition window");

  property p_pad_low;
    st_reg.conv_act && st_reg.conv_fall > res_bits(st_reg.cfg) |-> !SERIAL_OUT;
  endproperty
  a_pad_low: assert property (p_pad_low)
    else $error("serial output not low in padding");

  property p_ignore_low;
    rise && st_reg.rx_cnt == 4'h0 && !sdi_s |=> st_reg.rx_cnt == 4'h0;
  endproperty
  a_ignore_low: assert property (p_ignore_low)
    else $error("byte started without start bit");

  property p_frame_end;
    rise && st_reg.conv_act && st_reg.conv_rise == 5'h0F |=> !st_reg.conv_act;
  endproperty
  a_frame_end: assert property (p_frame_end)
    else $error("conversion did not end after 24 clocks");

  property p_ratiometric;
    PANEL.sample_hold && !st_reg.cfg.reference_mode_select
      && st_reg.cfg.channel_select == 3'h1 |-> PANEL.y_plus && PANEL.y_minus;
  endproperty
  a_ratiometric: assert property (p_ratiometric)
    else $error("drivers off during ratiometric conversion");

  // An overlapped byte may acquire while the previous result finishes
  property p_single_off;
    PANEL.sample_hold && st_reg.cfg.reference_mode_select && !st_reg.acq
      |-> !(PANEL.x_plus || PANEL.x_minus || PANEL.y_plus || PANEL.y_minus);
  endproperty
  a_single_off: assert property (p_single_off)
    else $error("drivers on during single-ended hold");

  property p_always_on;
    !st_reg.conv_act && !st_reg.acq && st_reg.cfg.channel_select == 3'h1
      && st_reg.cfg.power_down_select_high && st_reg.cfg.power_down_select_low
      |-> PANEL.y_plus && PANEL.y_minus && !PANEL.pen_touch_irq_en;
  endproperty
  a_always_on: assert property (p_always_on)
    else $error("drivers dropped with power-down select 11");

  property p_bresp_hold;
    S_AXI_RSP.bvalid && !S_AXI_REQ.bready |=> S_AXI_RSP.bvalid && $stable(S_AXI_RSP.bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response withdrawn");

  c_hold_12: cover property (fall && st_reg.rx_cnt == CTRL_BITS && !st_reg.rx_shift[3]);
  c_hold_8: cover property (fall && st_reg.rx_cnt == CTRL_BITS && st_reg.rx_shift[3]);
  c_overlap: cover property (rise && st_reg.conv_act && st_reg.rx_cnt == 4'h0 && sdi_s);
  c_axi_write: cover property (S_AXI_RSP.bvalid && S_AXI_REQ.bready);

endmodule : touch_adc_serial_sequencer

// File: touch_pkg.sv
// Constants and carrier types of the touch converter serial sequencer
package touch_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_CONTROL   = 8'h00;
  localparam logic [7:0]  OFF_TEST_CODE = 8'h04;
  localparam logic [7:0]  OFF_STATUS    = 8'h08;
  localparam logic [7:0]  OFF_RESULT    = 8'h0C;
  localparam logic        LINK_EN_RST   = 1'b1;
  localparam logic        USE_TEST_RST  = 1'b0;
  localparam logic [11:0] TEST_CODE_RST = 12'h000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // Serial frame counts, in shift clock edges
  // ----------------------------------------------------------------
  localparam logic [3:0]  ACQ_START_BITS = 4'h5;
  localparam logic [3:0]  CTRL_BITS      = 4'h8;
  localparam logic [4:0]  RES_BITS_HI    = 5'h0C;
  localparam logic [4:0]  RES_BITS_LO    = 5'h08;
  localparam logic [4:0]  RES_MSB        = 5'h0B;
  localparam logic [4:0]  CONV_RISES     = 5'h10;
  localparam logic [4:0]  OVERLAP_LEAD   = 5'h05;

  // ----------------------------------------------------------------
  // Channel and power-down codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  CH_TEMP0     = 3'h0;
  localparam logic [2:0]  CH_BATT      = 3'h2;
  localparam logic [2:0]  CH_TEMP1     = 3'h7;
  localparam logic [1:0]  PD_AUTO      = 2'h0;
  localparam logic [1:0]  PD_ALWAYS_ON = 2'h3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Control byte, first bit on the wire at the top
  typedef struct packed {
    logic       start;
    logic [2:0] channel_select;
    logic       mode_8bit;
    logic       reference_mode_select;
    logic       power_down_select_high;
    logic       power_down_select_low;
  } ctrl_t;

  typedef struct packed {
    logic       x_plus;
    logic       x_minus;
    logic       y_plus;
    logic       y_minus;
    logic       pen_diode;
    logic       temp_bias;
    logic       temp_bias_x91;
    logic       battery_div;
    logic       sample_hold;
    logic       reference_on;
    logic       converter_on;
    logic       pen_touch_irq_en;
    logic       ref_differential;
    logic [2:0] mux_select;
  } panel_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

endpackage : touch_pkg
